// *** hdl/exc_prio_pkg.sv ***
// Package: exception source indices, codes, opcode decode constants.
// Assumes a 16-bit instruction encoding supplied by the core decoder.
package exc_prio_pkg;
    // ------------------------------------------------------------
    // Sources, index 0 is highest priority
    // ------------------------------------------------------------
    localparam int NUM_SRC           = 13;
    localparam int SRC_POWER_ON      = 0;
    localparam int SRC_MANUAL        = 1;
    localparam int SRC_BRK_PRE       = 2;
    localparam int SRC_ADDR_FETCH    = 3;
    localparam int SRC_UNDEF         = 4;
    localparam int SRC_SLOT          = 5;
    localparam int SRC_TRAP          = 6;
    localparam int SRC_ADDR_DATA     = 7;
    localparam int SRC_BRK_POST      = 8;
    localparam int SRC_ADDR_DMA      = 9;
    localparam int SRC_NMI           = 10;
    localparam int SRC_EXT_IRQ       = 11;
    localparam int SRC_PERIPH        = 12;
    localparam int CODE_W            = 4;
    localparam logic [CODE_W-1:0] CODE_NONE = 4'hF;
    localparam logic [12:0] RESET_MASK = 13'h0003;
    localparam logic [12:0] SRC_RESET_VAL = 13'h0000;

    // ------------------------------------------------------------
    // Instruction classes reported by the decoder
    // ------------------------------------------------------------
    localparam int INSTR_CLASS_W = 4;
    typedef enum logic [INSTR_CLASS_W-1:0] {
        CLS_OTHER                       = 4'h0,
        CLS_JUMP_INSTR                  = 4'h1,
        CLS_JUMP_SUBROUTINE_INSTR       = 4'h2,
        CLS_BRANCH_ALWAYS_INSTR         = 4'h3,
        CLS_BRANCH_SUBROUTINE_INSTR     = 4'h4,
        CLS_RETURN_SUBROUTINE_INSTR     = 4'h5,
        CLS_RETURN_EXCEPTION_INSTR      = 4'h6,
        CLS_BRANCH_FALSE_DELAYED_INSTR  = 4'h7,
        CLS_BRANCH_TRUE_DELAYED_INSTR   = 4'h8,
        CLS_BRANCH_SUBROUTINE_FAR_INSTR = 4'h9,
        CLS_BRANCH_FAR_INSTR            = 4'hA,
        CLS_BRANCH_TRUE_INSTR           = 4'hB,
        CLS_BRANCH_FALSE_INSTR          = 4'hC,
        CLS_SOFTWARE_TRAP_INSTR         = 4'hD,
        CLS_LOAD_CTRL_REG_STATUS        = 4'hE,
        CLS_LOAD_CTRL_REG_STATUS_INC    = 4'hF
    } instr_class_t;
endpackage

// *** hdl/pc_change_tracker.sv ***
// Slot tracker: remembers whether the previous issued instruction
// was a delayed branch or changed the program counter.
// Assumes one instruction class strobe per issue slot from the core.
`timescale 1ns/100ps
module pc_change_tracker
    import exc_prio_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          issue_i,
    input  wire instr_class_t  class_i,
    input  wire logic          flush_i,
    output logic               in_slot_o
);
    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    function automatic logic is_delayed(input instr_class_t c);
        case (c)
            CLS_JUMP_INSTR, CLS_JUMP_SUBROUTINE_INSTR, CLS_BRANCH_ALWAYS_INSTR,
            CLS_BRANCH_SUBROUTINE_INSTR, CLS_RETURN_SUBROUTINE_INSTR,
            CLS_RETURN_EXCEPTION_INSTR, CLS_BRANCH_FALSE_DELAYED_INSTR,
            CLS_BRANCH_TRUE_DELAYED_INSTR, CLS_BRANCH_SUBROUTINE_FAR_INSTR,
            CLS_BRANCH_FAR_INSTR: is_delayed = 1'b1;
            default:              is_delayed = 1'b0;
        endcase
    endfunction

    function automatic logic is_pc_change(input instr_class_t c);
        case (c)
            CLS_BRANCH_TRUE_INSTR, CLS_BRANCH_FALSE_INSTR, CLS_SOFTWARE_TRAP_INSTR,
            CLS_LOAD_CTRL_REG_STATUS,
            CLS_LOAD_CTRL_REG_STATUS_INC: is_pc_change = 1'b1;
            default:                      is_pc_change = is_delayed(c);
        endcase
    endfunction

    typedef struct packed {
        logic in_slot;
    } trk_state_t;

    trk_state_t s_q;
    trk_state_t s_d;

    always_comb begin
        s_d = s_q;
        // A fresh issue beats the flush, so a branch in the ack cycle keeps its slot
        if (issue_i) begin
            s_d.in_slot = is_pc_change(class_i);
        end else if (flush_i) begin
            s_d.in_slot = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_slot_o = s_q.in_slot;
endmodule

// *** hdl/exception_priority_resolver.sv ***
// Exception priority resolver: latches requests, picks highest.
// Assumes the core acknowledges the presented winner with ack_i and
// that requesters hold or withdraw their level requests themselves.
//
// Contract
// - Four source groups feed the resolver
// - Simultaneous requests serviced one by one, priority
// - Power-on, manual reset, pre-break on top
// - Fetch error, undefined, slot, trap order
// - Data address error between trap, post-break
// - Post-break above controller address errors
// - Controller error, NMI, external, peripheral lowest
// - Undefined code in slot raises slot exception
// - PC-changing set, delayed branches included, for slot check
// - PC-changing set adds conditional, trap, load
`timescale 1ns/100ps
module exception_priority_resolver
    import exc_prio_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  wire logic               por_req_i,
    input  wire logic               manual_rst_req_i,
    input  wire logic               brk_pre_req_i,
    input  wire logic               addr_err_fetch_i,
    input  wire logic               undef_code_i,
    input  wire logic               trap_req_i,
    input  wire logic               addr_err_data_i,
    input  wire logic               brk_post_req_i,
    input  wire logic               addr_err_dma_i,
    input  wire logic               nmi_req_i,
    input  wire logic               ext_irq_req_i,
    input  wire logic               periph_irq_req_i,
    input  wire logic               withdraw_ext_i,
    input  wire logic               withdraw_periph_i,
    input  wire logic               issue_i,
    input  wire instr_class_t       class_i,
    input  wire logic               ack_i,
    output logic                    exc_valid_o,
    output logic [CODE_W-1:0]       exc_code_o,
    output logic [NUM_SRC-1:0]      pending_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [CODE_W-1:0] pick(input logic [NUM_SRC-1:0] p);
        pick = CODE_NONE;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                pick = CODE_W'(i);
            end
        end
    endfunction

    typedef struct packed {
        logic [NUM_SRC-1:0] pend;
        logic               valid;
        logic [CODE_W-1:0]  code;
    } res_state_t;

    res_state_t s_q;
    res_state_t s_d;
    logic       in_slot;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] merged;
    logic               flush;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Idle code must sit above every source index, or idle aliases one
    if (CODE_NONE < NUM_SRC) begin : g_idle_code_chk
        $error("idle code collides with a source index");
    end
    // Reset mask is applied bit for bit against the pending vector
    if ($bits(RESET_MASK) != NUM_SRC) begin : g_mask_width_chk
        $error("reset mask width differs from source count");
    end
    // Both resets must own the top two indices so they always win
    if (SRC_POWER_ON != 0 || SRC_MANUAL != 1) begin : g_reset_idx_chk
        $error("reset sources must hold the top two indices");
    end

    // ------------------------------------------------------------
    // Slot tracking
    // ------------------------------------------------------------
    assign flush = ack_i & s_q.valid;

    pc_change_tracker u_trk (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .issue_i   (issue_i),
        .class_i   (class_i),
        .flush_i   (flush),
        .in_slot_o (in_slot)
    );

    // ------------------------------------------------------------
    // Request collection and selection
    // ------------------------------------------------------------
    always_comb begin
        raw = '0;
        raw[SRC_POWER_ON]   = por_req_i;
        raw[SRC_MANUAL]     = manual_rst_req_i;
        raw[SRC_BRK_PRE]    = brk_pre_req_i;
        raw[SRC_ADDR_FETCH] = addr_err_fetch_i;
        // Undefined code after a branch is the slot case, not general
        raw[SRC_UNDEF]      = undef_code_i & ~in_slot;
        raw[SRC_SLOT]       = undef_code_i & in_slot;
        raw[SRC_TRAP]       = trap_req_i;
        raw[SRC_ADDR_DATA]  = addr_err_data_i;
        raw[SRC_BRK_POST]   = brk_post_req_i;
        raw[SRC_ADDR_DMA]   = addr_err_dma_i;
        raw[SRC_NMI]        = nmi_req_i;
        raw[SRC_EXT_IRQ]    = ext_irq_req_i;
        raw[SRC_PERIPH]     = periph_irq_req_i;

        s_d    = s_q;
        merged = s_q.pend;
        // Clear of the serviced bit first, so a fresh event still sets it
        if (flush) begin
            merged[s_q.code] = 1'b0;
        end
        if (withdraw_ext_i) begin
            merged[SRC_EXT_IRQ] = 1'b0;
        end
        if (withdraw_periph_i) begin
            merged[SRC_PERIPH] = 1'b0;
        end
        merged = merged | raw;
        if ((merged & RESET_MASK) != '0) begin
            merged = merged & RESET_MASK;
        end
        s_d.pend  = merged;
        s_d.valid = (merged != '0);
        s_d.code  = pick(merged);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.pend  <= SRC_RESET_VAL;
            s_q.valid <= 1'b0;
            s_q.code  <= CODE_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    assign exc_valid_o = s_q.valid;
    assign exc_code_o  = s_q.code;
    assign pending_o   = s_q.pend;
endmodule

// *** dv/exc_prio_chk.sv ***
// Checker: port assertions on the exception priority resolver.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/100ps
module exc_prio_chk
    import exc_prio_pkg::*;
(
    input wire logic                mclk_i,
    input wire logic                rst_n_i,
    input wire logic                por_req_i,
    input wire logic                manual_rst_req_i,
    input wire logic                trap_req_i,
    input wire logic                nmi_req_i,
    input wire logic                periph_irq_req_i,
    input wire logic                withdraw_periph_i,
    input wire logic                undef_code_i,
    input wire logic                issue_i,
    input wire instr_class_t        class_i,
    input wire logic                ack_i,
    input wire logic                exc_valid_o,
    input wire logic [CODE_W-1:0]   exc_code_o,
    input wire logic [NUM_SRC-1:0]  pending_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    wire logic rst_in = por_req_i | manual_rst_req_i;
    wire logic rst_held = |(pending_o & RESET_MASK);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_wipes: assert property (rst_in |=> (pending_o & ~RESET_MASK) == 13'h0000)
        else $error("request kept beside reset");
    a_valid_any: assert property (exc_valid_o == (|pending_o))
        else $error("valid disagrees with pending");
    a_idle_code: assert property (!exc_valid_o |-> exc_code_o == CODE_NONE)
        else $error("code shown while idle");
    a_top_winner: assert property (exc_valid_o |-> pending_o[exc_code_o]
        && (pending_o & ((13'h0001 << exc_code_o) - 13'h0001)) == 13'h0000)
        else $error("winner is not highest pending");
    a_trap_taken: assert property (trap_req_i && !rst_in && !rst_held |=> pending_o[SRC_TRAP])
        else $error("trap request lost");
    a_nmi_ack: assert property (ack_i && exc_code_o == SRC_NMI && !nmi_req_i
        |=> !pending_o[SRC_NMI]) else $error("serviced nmi still pending");
    a_periph_wd: assert property (withdraw_periph_i && !periph_irq_req_i
        |=> !pending_o[SRC_PERIPH]) else $error("withdrawn request still pending");
    a_slot_raise: assert property (issue_i && class_i != CLS_OTHER && !ack_i
        ##1 undef_code_i && !issue_i && !ack_i && !rst_in && !rst_held
        |=> pending_o[SRC_SLOT]) else $error("slot exception missed");
    a_undef_plain: assert property (issue_i && class_i == CLS_OTHER && !ack_i
        ##1 undef_code_i && !issue_i && !ack_i && !rst_in && !rst_held
        |=> pending_o[SRC_UNDEF]) else $error("undefined code missed");
endmodule
bind exception_priority_resolver exc_prio_chk chk_u (.mclk_i, .rst_n_i, .por_req_i,
    .manual_rst_req_i, .trap_req_i, .nmi_req_i, .periph_irq_req_i, .withdraw_periph_i,
    .undef_code_i, .issue_i, .class_i, .ack_i, .exc_valid_o, .exc_code_o, .pending_o);

// *** dv/core_ack_model.sv ***
// Core model: services the presented winner while enabled.
// Assumes the resolver's valid output is registered.
`timescale 1ns/100ps
module core_ack_model (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic go_i,
    input  wire logic valid_i,
    output logic      ack_o
);
    // Gap cycle after each ack, so the next winner settles first
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= go_i && valid_i && !ack_o;
        end
    end
endmodule

// *** dv/tb_top.sv ***
// Testbench: drives requests, checks winner order and slot decode.
// Assumes the resolver, its checker bind and the core model.
`timescale 1ns/100ps
module tb_top
    import exc_prio_pkg::*;
;
    logic               mclk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [NUM_SRC-1:0] req = 13'h0000;
    logic               wd_ext = 1'b0;
    logic               wd_per = 1'b0;
    logic               issue = 1'b0;
    instr_class_t       cls = CLS_OTHER;
    logic               go = 1'b0;
    logic               ack;
    logic               valid;
    logic [CODE_W-1:0]  code;
    logic [NUM_SRC-1:0] pending;
    int                 miscompares = 0;
    int                 n_tests = 0;
    int                 cyc = 0;
    always #25 mclk_i = ~mclk_i;
    exception_priority_resolver dut_u (.mclk_i, .rst_n_i, .por_req_i(req[0]),
        .manual_rst_req_i(req[1]), .brk_pre_req_i(req[2]), .addr_err_fetch_i(req[3]),
        .undef_code_i(req[4]), .trap_req_i(req[6]), .addr_err_data_i(req[7]),
        .brk_post_req_i(req[8]), .addr_err_dma_i(req[9]), .nmi_req_i(req[10]),
        .ext_irq_req_i(req[11]), .periph_irq_req_i(req[12]), .withdraw_ext_i(wd_ext),
        .withdraw_periph_i(wd_per), .issue_i(issue), .class_i(cls), .ack_i(ack),
        .exc_valid_o(valid), .exc_code_o(code), .pending_o(pending));
    core_ack_model core_u (.mclk_i, .rst_n_i, .go_i(go), .valid_i(valid), .ack_o(ack));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Core acks each winner; codes must come out in this order
    task automatic drain(input int q[$]);
        int w;
        go = 1'b1;
        foreach (q[i]) begin
            w = 0;
            while (ack !== 1'b1 && w < 50) begin
                step(1);
                w++;
            end
            chk(13'(code), 13'(q[i]));
            step(1);
        end
        step(2);
        go = 1'b0;
        chk(13'(valid), 13'h0000);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_walk();
        issue = 1'b1;
        step(1);
        issue = 1'b0;
        req = 13'h1FDC;
        step(1);
        req = 13'h0000;
        step(1);
        chk(pending, 13'h1FDC);
        drain('{2, 3, 4, 6, 7, 8, 9, 10, 11, 12});
    endtask
    task automatic t_reset();
        // Trap already pending, so the reset must wipe it as well
        req = 13'h0040;
        step(1);
        req = 13'h0443;
        step(1);
        req = 13'h0040;
        step(2);
        req = 13'h0000;
        chk(pending, 13'h0003);
        drain('{0, 1});
    endtask
    task automatic t_slot();
        for (int c = 0; c < 16; c++) begin
            issue = 1'b1;
            cls = instr_class_t'(c);
            step(1);
            issue = 1'b0;
            req[4] = 1'b1;
            step(1);
            req[4] = 1'b0;
            step(1);
            chk(pending, 13'h0010 << (c != 0));
            drain('{(c == 0) ? 4 : 5});
        end
    endtask
    task automatic t_withdraw();
        req = 13'h1800;
        step(1);
        req = 13'h0000;
        step(1);
        chk(pending, 13'h1800);
        wd_ext = 1'b1;
        wd_per = 1'b1;
        step(1);
        wd_ext = 1'b0;
        wd_per = 1'b0;
        step(1);
        chk(pending, 13'h0000);
    endtask
    // Hang guard, well above the under two hundred cycles the run needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        step(5);
        rst_n_i = 1'b1;
        step(2);
        chk(pending, SRC_RESET_VAL);
        chk(13'(code), 13'(CODE_NONE));
        t_walk();
        t_reset();
        t_slot();
        t_withdraw();
        close_out();
    end
endmodule
